// ### rtl/mio_regs.svh
// Register offsets, field positions, reset values and limits of the external I/O port
`ifndef MIO_REGS_SVH
`define MIO_REGS_SVH
// ==========================================================
// Register byte offsets
`define MIO_CTRL_OFS     8'h00
`define MIO_STATUS_OFS   8'h04
`define MIO_RXCHAR_OFS   8'h08
`define MIO_CMD_OFS      8'h0C
`define MIO_ERRLOG_OFS   8'h10
// ==========================================================
// Control fields
`define MIO_CTRL_PAUSE_EN 0
`define MIO_CTRL_RUN      1
`define MIO_CTRL_SPINDLE  2
`define MIO_CTRL_ACK      3
`define MIO_CTRL_RESET    3'h0
// Received character fields
`define MIO_RX_END        8
// Command fields
`define MIO_CMD_CODE_LSB  0
`define MIO_CMD_PARM_LSB  16
// ==========================================================
// Error numbers
`define MIO_ERR_BLOCK     8'h0E
`define MIO_ERR_CMD       8'h0F
`define MIO_ERR_PARM      8'h12
`define MIO_ERR_SIZE      8'h20
// ==========================================================
// Limits
`define MIO_BLOCK_MAX     8'h80
`define MIO_DATA_MAX      24'hA00000
`define MIO_CMD_LAST      8'h3F
`define MIO_PARM_MAX      16'h7FFF
`endif

// ### rtl/mio_pkg.sv
// Types shared by the external I/O port modules
package mio_pkg;
  // AXI response codes
  typedef enum logic [1:0] {MIO_OKAY = 2'h0, MIO_SLVERR = 2'h2} mio_resp_e;
  // Halt state of command execution
  typedef enum logic {MIO_ST_RUN, MIO_ST_HALT} mio_state_e;
  // Error log contents
  typedef struct packed {
    logic       valid;
    logic [7:0] detail;
    logic [7:0] number;
  } mio_log_s;
endpackage : mio_pkg

// ### rtl/mio_sync_if.sv
// Carrier between the pin synchroniser and the port logic
`timescale 1ns/10ps
interface mio_sync_if;
  logic [1:0] raw;   // Pin levels straight from the terminal block
  logic [1:0] level; // Filtered levels on aclk
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface : mio_sync_if

// ### rtl/mio_sync.sv
// Three-stage synchroniser with agreement filter for the input pins
`timescale 1ns/10ps
module mio_sync (
  input wire logic aclk,
  input wire logic aresetn,
  mio_sync_if.sync pins
);
  logic [1:0] s1_q; // First stage, read only by second
  logic [1:0] s2_q; // Second stage
  logic [1:0] s3_q; // Third stage
  logic [1:0] lvl_q; // Accepted level

  // ==========================================================
  // Shift chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
    end else begin
      s1_q <= pins.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign pins.level = lvl_q;
endmodule : mio_sync

// ### rtl/mio_port.sv
// External I/O port with error checking and error log, AXI4-Lite slave
`timescale 1ns/10ps
`include "mio_regs.svh"
module mio_port (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output mio_pkg::mio_resp_e    s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output mio_pkg::mio_resp_e    s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             pause_resume_input,
  input  wire logic             reserved_input,
  output logic                  spindle_state_output,
  output logic                  error_state_output,
  output logic                  reserved_output,
  output logic                  exec_enable
);
  import mio_pkg::*;

  // ==========================================================
  // Declarations
  mio_sync_if sif ();                 // Pin carrier
  logic              aw_full_q;      // Write address held
  logic [7:0]        awaddr_q;       // Held write address
  logic              w_full_q;       // Write data held
  logic [31:0]       wdata_q;        // Held write data
  logic [3:0]        wstrb_q;        // Held byte strobes
  logic              bvalid_q;       // Write response pending
  mio_resp_e         bresp_q;        // Write response code
  logic              rvalid_q;       // Read data pending
  mio_resp_e         rresp_q;        // Read response code
  logic [31:0]       rdata_q;        // Read data
  logic              do_write;       // Both halves present
  logic [2:0]        ctrl_q;         // Pause enable, run, spindle
  mio_state_e        state_q;        // Halt state
  logic [7:0]        blk_cnt_q;      // Characters in current block
  logic [23:0]       total_q;        // Characters received in total
  mio_log_s          log_q;          // Latest error
  logic              ack;            // Exit key pulse
  logic              char_wr;        // Character accepted
  logic              cmd_wr;         // Command accepted
  logic [7:0]        err_num;        // Error raised this cycle
  logic [7:0]        err_det;        // Detail for the log
  logic              pause_lvl;      // Filtered pause pin

  // ==========================================================
  // Functions
  // Register decode, shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `MIO_CTRL_OFS) || (a == `MIO_STATUS_OFS) || (a == `MIO_RXCHAR_OFS) ||
             (a == `MIO_CMD_OFS) || (a == `MIO_ERRLOG_OFS);
  endfunction : mapped

  // Incrementing count that never wraps
  function automatic logic [23:0] sat_inc(input logic [23:0] v);
    sat_inc = (v == 24'hFFFFFF) ? v : v + 24'h000001;
  endfunction : sat_inc

  // ==========================================================
  // Pin synchroniser
  assign sif.raw = {reserved_input, pause_resume_input};
  mio_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (sif.sync)
  );
  assign pause_lvl = sif.level[0];

  // ==========================================================
  // AXI write channels: address and data taken in either order
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign do_write      = aw_full_q && w_full_q && !bvalid_q;

  // Address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  // Data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end

  // Write response, error for unmapped or read-only words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= MIO_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (mapped(awaddr_q) && awaddr_q != `MIO_STATUS_OFS && awaddr_q != `MIO_ERRLOG_OFS)
                  ? MIO_OKAY : MIO_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ==========================================================
  // AXI read channel, one read in flight
  assign s_axi_arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= MIO_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped({s_axi_araddr[7:2], 2'b00}) ? MIO_OKAY : MIO_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        `MIO_CTRL_OFS:   rdata_q <= {29'h0, ctrl_q};
        // Reserved input shown but drives nothing
        `MIO_STATUS_OFS: rdata_q <= {27'h0, sif.level[1], pause_lvl, state_q == MIO_ST_HALT,
                                     error_state_output, exec_enable};
        `MIO_ERRLOG_OFS: rdata_q <= {15'h0, log_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ==========================================================
  // Control register; the reserved input has no setting here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `MIO_CTRL_RESET;
    end else if (do_write && awaddr_q == `MIO_CTRL_OFS && wstrb_q[0]) begin
      ctrl_q <= wdata_q[2:0];
    end
  end

  // Exit key is a write-one pulse, never stored
  assign ack = do_write && awaddr_q == `MIO_CTRL_OFS && wstrb_q[0] && wdata_q[`MIO_CTRL_ACK];

  // Data writes are dropped while halted, so the host must stop sending
  assign char_wr = do_write && awaddr_q == `MIO_RXCHAR_OFS && wstrb_q[0] && state_q == MIO_ST_RUN;
  assign cmd_wr  = do_write && awaddr_q == `MIO_CMD_OFS && state_q == MIO_ST_RUN;

  // ==========================================================
  // Error detection, one error per accepted write
  // Priority is size, block, command, parameter; only the first match is logged
  always_comb begin
    err_num = 8'h00;
    err_det = 8'h00;
    if (char_wr && total_q >= `MIO_DATA_MAX) begin
      err_num = `MIO_ERR_SIZE;
      err_det = wdata_q[7:0];
    end else if (char_wr && blk_cnt_q >= `MIO_BLOCK_MAX - 8'h01) begin
      err_num = `MIO_ERR_BLOCK;
      err_det = wdata_q[7:0];
    end else if (cmd_wr && wdata_q[7:`MIO_CMD_CODE_LSB] > `MIO_CMD_LAST) begin
      err_num = `MIO_ERR_CMD;
      err_det = wdata_q[7:0];
    end else if (cmd_wr && wdata_q[31:`MIO_CMD_PARM_LSB] > `MIO_PARM_MAX) begin
      err_num = `MIO_ERR_PARM;
      err_det = wdata_q[7:0];
    end
  end

  // Character counters; a block ends with its end-marked character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_cnt_q <= 8'h00;
      total_q   <= 24'h000000;
    end else if (char_wr) begin
      total_q   <= sat_inc(total_q);
      blk_cnt_q <= (wdata_q[`MIO_RX_END] || err_num != 8'h00) ? 8'h00 : blk_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Halt state: a new error wins over an acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= MIO_ST_RUN;
    end else if (err_num != 8'h00) begin
      state_q <= MIO_ST_HALT;
    end else if (ack) begin
      state_q <= MIO_ST_RUN;
    end
  end

  // Error log survives the acknowledge; only reset or a newer error changes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_q <= '0;
    end else if (err_num != 8'h00) begin
      log_q <= '{valid: 1'b1, detail: err_det, number: err_num};
    end
  end

  // ==========================================================
  // Execution gate; pause only matters in run mode with the function on
  assign exec_enable = ctrl_q[`MIO_CTRL_RUN] && state_q == MIO_ST_RUN &&
                       !(ctrl_q[`MIO_CTRL_PAUSE_EN] && !pause_lvl);

  // Fixed-function outputs
  assign spindle_state_output = !ctrl_q[`MIO_CTRL_SPINDLE];
  assign error_state_output   = state_q == MIO_ST_HALT;
  assign reserved_output      = 1'b0;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RESUME: assert property (ctrl_q == 3'h3 && state_q == MIO_ST_RUN && pause_lvl |-> exec_enable)
    else $error("Pause high did not allow execution");
  AST_PAUSE: assert property (ctrl_q[0] && !pause_lvl |-> !exec_enable)
    else $error("Pause low did not stop execution");
  AST_RUN_ONLY: assert property (!ctrl_q[`MIO_CTRL_RUN] |-> !exec_enable)
    else $error("Execution outside run mode");
  AST_PAUSE_OFF: assert property (!ctrl_q[0] && $changed(pause_lvl) && $stable(ctrl_q) && $stable(state_q)
                                  |-> $stable(exec_enable))
    else $error("Disabled pause input changed execution");
  AST_SPINDLE: assert property (spindle_state_output != ctrl_q[`MIO_CTRL_SPINDLE])
    else $error("Spindle output polarity wrong");
  AST_SPINDLE_WR: assert property (do_write && awaddr_q == `MIO_CTRL_OFS && wstrb_q[0] && wdata_q[`MIO_CTRL_SPINDLE]
                                   |=> !spindle_state_output)
    else $error("Spindle output did not follow internal state");
  AST_ERR_OUT: assert property (err_num != 8'h00 |=> error_state_output)
    else $error("Error output not raised");
  AST_RSV_OUT: assert property (!reserved_output)
    else $error("Reserved output not low");
  AST_LOG: assert property (err_num == 8'h00 |=> $stable(log_q))
    else $error("Error log changed without error");
  AST_BLOCK: assert property (char_wr && blk_cnt_q == 8'h7F && total_q < `MIO_DATA_MAX
                              |=> log_q.number == `MIO_ERR_BLOCK)
    else $error("Block length error missed");
  AST_CMD: assert property (cmd_wr && wdata_q[7:0] > `MIO_CMD_LAST |=> log_q.number == `MIO_ERR_CMD)
    else $error("Unsupported command missed");
  AST_PARM: assert property (cmd_wr && wdata_q[7:0] <= `MIO_CMD_LAST && wdata_q[31:16] > `MIO_PARM_MAX
                             |=> log_q.number == `MIO_ERR_PARM)
    else $error("Parameter range error missed");
  AST_SIZE: assert property (char_wr && total_q >= `MIO_DATA_MAX |=> log_q.number == `MIO_ERR_SIZE)
    else $error("Data size error missed");
  AST_HALT: assert property (error_state_output && !ack |=> error_state_output && !exec_enable)
    else $error("Halt released without exit");
  AST_SYNC: assert property ($changed(pause_lvl) |-> $past(pause_resume_input, 3) == pause_lvl)
    else $error("Pause level not synchronised");

  // ==========================================================
  // Main scenarios, to see that the bench reaches them
  CV_ERROR: cover property (err_num != 8'h00 ##[1:20] ack);
  // A command arriving while halted is dropped, not checked
  CV_DROP: cover property (state_q == MIO_ST_HALT && do_write && awaddr_q == `MIO_CMD_OFS);
  CV_PAUSE: cover property (exec_enable ##1 !exec_enable ##[1:20] exec_enable);
  CV_BLOCK: cover property (err_num == `MIO_ERR_BLOCK);
endmodule : mio_port

// ### bench/mio_ext_dev.sv
// Model of the external device wired to the terminal block input pins
`timescale 1ns/10ps
module mio_ext_dev (
  input  wire logic       aclk,
  input  wire logic       want_run,
  input  wire logic       want_spare,
  input  wire logic [2:0] lag,
  output logic            pause_resume_input,
  output logic            reserved_input
);
  // ==========================================================
  // Pin drive
  logic [7:0] hist_q; // Recent requested pause levels, newest in bit 0

  // Quiet pins until the first clock edge
  initial begin
    hist_q = 8'h00;
    pause_resume_input = 1'b0;
    reserved_input = 1'b0;
  end

  // Pins move 13 ns after the edge so they look unrelated to aclk
  // Lag lets the device answer promptly or slowly
  always @(posedge aclk) begin
    hist_q <= {hist_q[6:0], want_run};
    pause_resume_input <= #13 hist_q[lag];
    reserved_input <= #13 want_spare; // No function behind this pin
  end
endmodule : mio_ext_dev

// ### bench/tb.sv
// Self-checking bench for the external I/O port
`timescale 1ns/10ps
`include "mio_regs.svh"
module tb;
  import mio_pkg::*;
  // ==========================================================
  // Signals
  logic        aclk = 1'b0;   // 25 MHz system clock
  logic        aresetn = 1'b0; // Active-low reset
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  mio_resp_e   bresp, rresp;
  logic        spindle, err_out, res_out, exec, pause_pin, spare_pin;
  logic        dev_pause = 1'b0, dev_spare = 1'b0; // Levels asked of the device
  logic [2:0]  dev_lag = 3'h0;
  logic [33:0] rq[$];     // Expected {rresp, rdata}
  mio_resp_e   bq[$];     // Expected bresp
  int          fails = 0;
  int          comparisons = 0;

  always #20 aclk = ~aclk;

  mio_port i_mio_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pause_resume_input(pause_pin),
    .reserved_input(spare_pin), .spindle_state_output(spindle), .error_state_output(err_out),
    .reserved_output(res_out), .exec_enable(exec));

  mio_ext_dev i_mio_ext_dev (.aclk(aclk), .want_run(dev_pause), .want_spare(dev_spare), .lag(dev_lag),
    .pause_resume_input(pause_pin), .reserved_input(spare_pin));

  // ==========================================================
  // Reporting and comparison
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Pins are looked at mid-cycle, where they have settled
  task automatic cmp_pin(input logic exp, input string what);
    @(negedge aclk);
    comparisons++;
    if (((what == "spindle") ? spindle : (what == "error") ? err_out : (what == "spare") ? res_out : exec) !== exp) begin
      fails++;
      $display("BAD %0t pin %s wrong", $time, what);
    end
  endtask : cmp_pin

  task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t read got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_resp(input mio_resp_e got, input mio_resp_e exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t write response %h", $time, got);
    end
  endtask : cmp_resp

  // Results are taken mid-cycle, in the one cycle where both sides agree
  always @(negedge aclk) begin
    if (bvalid === 1'b1 && bready && bq.size() == 0) begin
      fails++;
      $display("BAD %0t write response without request", $time);
    end else if (bvalid === 1'b1 && bready) begin
      cmp_resp(bresp, bq.pop_front());
    end
    if (rvalid === 1'b1 && rready) begin
      cmp_word({rresp, rdata}, (rq.size() > 0) ? rq.pop_front() : 34'h3_FFFF_FFFF);
    end
  end

  // ==========================================================
  // Bus master tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input mio_resp_e er);
    int n;
    bit pa, pw, pb, ha, hw, hb;
    pa = 1;
    pw = 1;
    pb = 1;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && (pa || pw || pb); n++) begin
      @(negedge aclk);
      ha = pa && awready;
      hw = pw && wready;
      hb = pb && bvalid;
      @(posedge aclk);
      if (ha) begin pa = 0; awvalid <= 1'b0; end
      if (hw) begin pw = 0; wvalid <= 1'b0; end
      if (hb) begin pb = 0; bready <= 1'b0; end
    end
    if (n == 50) begin fails++; report_and_stop(); end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    int n;
    bit pa, pr, ha, hr;
    pa = 1;
    pr = 1;
    rq.push_back(exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && (pa || pr); n++) begin
      @(negedge aclk);
      ha = pa && arready;
      hr = pr && rvalid;
      @(posedge aclk);
      if (ha) begin pa = 0; arvalid <= 1'b0; end
      if (hr) begin pr = 0; rready <= 1'b0; end
    end
    if (n == 50) begin fails++; report_and_stop(); end
  endtask : axi_rd

  // Raise one error, check halt, try a dropped write, check log, acknowledge, check log again
  task automatic err_case(input logic [7:0] a, input logic [31:0] d, input logic [7:0] num);
    logic [33:0] log_v;
    log_v = {2'h0, 15'h0, 1'b1, d[7:0], num};
    axi_wr(a, d, MIO_OKAY);
    cmp_pin(1'b1, "error");
    cmp_pin(1'b0, "exec");
    axi_wr(`MIO_CMD_OFS, 32'h0000_007F, MIO_OKAY);
    axi_rd(`MIO_ERRLOG_OFS, log_v);
    axi_wr(`MIO_CTRL_OFS, 32'h0000_000A, MIO_OKAY);
    cmp_pin(1'b0, "error");
    cmp_pin(1'b1, "exec");
    axi_rd(`MIO_ERRLOG_OFS, log_v);
  endtask : err_case

  // ==========================================================
  // Main sequence
  initial begin
    int i;
    logic [7:0] ch;
    void'($urandom(32'h7F80));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cmp_pin(1'b1, "spindle");
    cmp_pin(1'b0, "error");
    cmp_pin(1'b0, "spare");
    axi_rd(`MIO_CTRL_OFS, 34'h0);
    axi_rd(`MIO_ERRLOG_OFS, 34'h0);
    axi_rd(8'h14, {MIO_SLVERR, 32'h0});
    axi_wr(`MIO_STATUS_OFS, 32'h1, MIO_SLVERR);
    axi_wr(`MIO_CTRL_OFS, 32'h0000_0004, MIO_OKAY);
    cmp_pin(1'b0, "spindle");
    axi_wr(`MIO_CTRL_OFS, 32'h0, MIO_OKAY);
    cmp_pin(1'b1, "spindle");
    // Spare pin has no function but its level is visible
    dev_spare <= 1'($urandom);
    dev_lag <= 3'($urandom);
    axi_wr(`MIO_CTRL_OFS, 32'h0000_0002, MIO_OKAY);
    repeat (16) @(posedge aclk);
    cmp_pin(1'b1, "exec");
    axi_rd(`MIO_STATUS_OFS, {2'h0, 27'h0, dev_spare, 4'h1});
    axi_wr(`MIO_CTRL_OFS, 32'h0000_0003, MIO_OKAY);
    repeat (16) @(posedge aclk);
    cmp_pin(1'b0, "exec");
    @(posedge aclk);
    dev_pause <= 1'b1;
    for (i = 0; i < 20 && pause_pin !== 1'b1; i++) @(posedge aclk);
    if (i == 20) begin fails++; report_and_stop(); end
    @(posedge aclk);
    cmp_pin(1'b0, "exec");
    repeat (8) @(posedge aclk);
    cmp_pin(1'b1, "exec");
    axi_wr(`MIO_CTRL_OFS, 32'h0000_0001, MIO_OKAY);
    cmp_pin(1'b0, "exec");
    axi_wr(`MIO_CTRL_OFS, 32'h0000_0002, MIO_OKAY);
    // Block length: 127 characters pass, the 128th trips
    for (i = 0; i < 127; i++) axi_wr(`MIO_RXCHAR_OFS, {24'h0, 8'($urandom) & 8'h3F}, MIO_OKAY);
    cmp_pin(1'b0, "error");
    ch = 8'($urandom) & 8'h3F;
    err_case(`MIO_RXCHAR_OFS, {24'h0, ch}, `MIO_ERR_BLOCK);
    // Highest legal code and parameter are accepted
    axi_wr(`MIO_CMD_OFS, {1'b0, 15'($urandom), 16'h003F}, MIO_OKAY);
    axi_wr(`MIO_CMD_OFS, 32'h7FFF_0001, MIO_OKAY);
    cmp_pin(1'b0, "error");
    err_case(`MIO_CMD_OFS, 32'h0000_0040, `MIO_ERR_CMD);
    err_case(`MIO_CMD_OFS, 32'h8000_0001, `MIO_ERR_PARM);
    // Pause function off: the pin falling must not stop execution
    dev_pause <= 1'b0;
    repeat (16) @(posedge aclk);
    cmp_pin(1'b1, "exec");
    repeat (4) @(posedge aclk);
    report_and_stop();
  end
endmodule : tb
